//--- crf_core_regs.sv
// cpu programmer-visible state: general registers, pc, condition codes
`timescale 1ns/10ps
`default_nettype none
module crf_core_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  // general register access
  input wire logic [2:0] rd_a_idx,
  input wire crf_pkg::crf_view_e rd_a_view,
  output logic [31:0] rd_a_data,
  input wire logic [2:0] rd_b_idx,
  input wire crf_pkg::crf_view_e rd_b_view,
  output logic [31:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire crf_pkg::crf_view_e wr_view,
  input wire logic [31:0] wr_data,
  input wire logic sp_push,
  input wire logic sp_pop,
  output logic [31:0] stack_pointer,
  // program counter
  input wire logic vec_valid,
  input wire logic [23:0] vec_addr,
  input wire logic fetch_take,
  input wire logic pc_load,
  input wire logic [23:0] pc_target,
  output logic [23:0] program_counter,
  output logic [15:0] fetch_addr,
  output logic core_ready,
  // exceptions and interrupts
  input wire logic exc_start,
  input wire logic irq_req,
  input wire logic nmi_req,
  output logic irq_accept,
  // condition code access
  input wire crf_pkg::crf_ccop_e ccr_op,
  input wire logic [7:0] ccr_val,
  input wire logic [7:0] flag_wr_mask,
  input wire logic [7:0] flag_wr_val,
  output logic [7:0] condition_code_register,
  input wire logic [3:0] bcc_cond,
  output logic bcc_taken,
  // arithmetic
  input wire logic alu_req,
  input wire crf_pkg::crf_aluop_e alu_op,
  input wire crf_pkg::crf_size_e alu_size,
  input wire logic [31:0] alu_a,
  input wire logic [31:0] alu_b,
  output logic alu_busy,
  output logic alu_done,
  output logic [31:0] alu_result,
  // power
  input wire logic sleep_req,
  output logic power_down
);

  typedef enum logic [1:0] {
    ST_VECTOR, ST_RUN, ST_BUSY, ST_SLEEP
  } crf_state_e;

  crf_state_e state_reg, state_next;
  logic [23:0] pc_reg, pc_next;
  logic [7:0] ccr_reg, ccr_next;
  logic [4:0] cnt_reg, cnt_next;
  crf_pkg::crf_aluop_e op_reg, op_next;
  crf_pkg::crf_size_e size_reg, size_next;
  logic [31:0] a_reg, a_next, b_reg, b_next;
  logic cin_reg, cin_next;
  logic [31:0] res_reg, res_next;
  logic done_reg, done_next;
  logic pc_ok, is_addsub, is_ext;
  logic [31:0] f_sum;
  logic f_n, f_z, f_v, f_c, f_h;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // busy states left after the first busy state
  function automatic logic [4:0] lat_of(input crf_pkg::crf_aluop_e op);
    int n;
    case (op)
      crf_pkg::ALU_MULB, crf_pkg::ALU_DIVB:
        n = crf_pkg::LAT_MULDIV_SHORT;
      crf_pkg::ALU_MULW, crf_pkg::ALU_DIVW:
        n = crf_pkg::LAT_MULDIV_LONG;
      default: n = crf_pkg::LAT_ADDSUB;
    endcase
    return 5'(n - 1);
  endfunction

  // unsigned multiply and divide; remainder sits above the quotient
  function automatic logic [31:0] muldiv(input crf_pkg::crf_aluop_e op,
                                         input logic [31:0] a,
                                         input logic [31:0] b);
    logic [15:0] q8, r8;
    logic [31:0] q16, r16;
    q8 = 16'hffff;
    r8 = 16'hffff;
    q16 = 32'hffff_ffff;
    r16 = 32'hffff_ffff;
    // divide by zero gives all ones, never unknown
    if (b[7:0] != 8'h00) begin
      q8 = a[15:0] / {8'h00, b[7:0]};
      r8 = a[15:0] % {8'h00, b[7:0]};
    end
    if (b[15:0] != 16'h0000) begin
      q16 = a / {16'h0000, b[15:0]};
      r16 = a % {16'h0000, b[15:0]};
    end
    case (op)
      crf_pkg::ALU_MULB: muldiv = {16'h0000, 16'(a[7:0]) * 16'(b[7:0])};
      crf_pkg::ALU_DIVB: muldiv = {16'h0000, r8[7:0], q8[7:0]};
      crf_pkg::ALU_MULW: muldiv = 32'(a[15:0]) * 32'(b[15:0]);
      default: muldiv = {r16[15:0], q16[15:0]};
    endcase
  endfunction

  // sixteen branch tests on n, z, v, c
  function automatic logic cond_eval(input logic [3:0] c,
                                     input logic [7:0] f);
    logic n, z, v, cy;
    n = f[crf_pkg::CCR_N];
    z = f[crf_pkg::CCR_Z];
    v = f[crf_pkg::CCR_V];
    cy = f[crf_pkg::CCR_C];
    case (c)
      4'h0: cond_eval = 1'b1;
      4'h1: cond_eval = 1'b0;
      4'h2: cond_eval = ~(cy | z);
      4'h3: cond_eval = cy | z;
      4'h4: cond_eval = ~cy;
      4'h5: cond_eval = cy;
      4'h6: cond_eval = ~z;
      4'h7: cond_eval = z;
      4'h8: cond_eval = ~v;
      4'h9: cond_eval = v;
      4'ha: cond_eval = ~n;
      4'hb: cond_eval = n;
      4'hc: cond_eval = ~(n ^ v);
      4'hd: cond_eval = n ^ v;
      4'he: cond_eval = ~(z | (n ^ v));
      default: cond_eval = z | (n ^ v);
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // submodules

  crf_gpr_bank u_bank (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rd_a_idx(rd_a_idx),
    .rd_a_view(rd_a_view),
    .rd_a_data(rd_a_data),
    .rd_b_idx(rd_b_idx),
    .rd_b_view(rd_b_view),
    .rd_b_data(rd_b_data),
    .wr_en(wr_en),
    .wr_idx(wr_idx),
    .wr_view(wr_view),
    .wr_data(wr_data),
    .sp_push(sp_push),
    .sp_pop(sp_pop),
    .stack_pointer(stack_pointer)
  );

  crf_flag_unit u_flags (
    .op_a(a_reg),
    .op_b(b_reg),
    .carry_in(cin_reg),
    .op(op_reg),
    .size(size_reg),
    .sum_result(f_sum),
    .flag_n(f_n),
    .flag_z(f_z),
    .flag_v(f_v),
    .flag_c(f_c),
    .flag_h(f_h)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing, program counter and condition codes

  assign pc_ok = (state_reg == ST_RUN) || (state_reg == ST_BUSY);
  assign is_addsub = (op_reg == crf_pkg::ALU_ADD)
                     || (op_reg == crf_pkg::ALU_ADDX)
                     || (op_reg == crf_pkg::ALU_SUB)
                     || (op_reg == crf_pkg::ALU_SUBX)
                     || (op_reg == crf_pkg::ALU_CMP)
                     || (op_reg == crf_pkg::ALU_NEG);
  assign is_ext = (op_reg == crf_pkg::ALU_ADDX)
                  || (op_reg == crf_pkg::ALU_SUBX);

  // ccr writers in rising priority: alu, ccr ops, flag writes, exception
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    ccr_next = ccr_reg;
    cnt_next = cnt_reg;
    op_next = op_reg;
    size_next = size_reg;
    a_next = a_reg;
    b_next = b_reg;
    cin_next = cin_reg;
    res_next = res_reg;
    done_next = 1'b0;
    case (state_reg)
      ST_VECTOR: begin
        if (vec_valid) begin
          pc_next = vec_addr;
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (alu_req) begin
          op_next = alu_op;
          size_next = alu_size;
          a_next = alu_a;
          b_next = alu_b;
          cin_next = ccr_reg[crf_pkg::CCR_C];
          cnt_next = lat_of(alu_op);
          state_next = ST_BUSY;
        end else if (sleep_req) begin
          state_next = ST_SLEEP;
        end
      end
      ST_BUSY: begin
        if (cnt_reg == 5'h00) begin
          state_next = ST_RUN;
          done_next = 1'b1;
          res_next = is_addsub ? f_sum : muldiv(op_reg, a_reg, b_reg);
          // multiply and divide leave the flags unchanged
          if (is_addsub) begin
            ccr_next[crf_pkg::CCR_H] = f_h;
            ccr_next[crf_pkg::CCR_N] = f_n;
            // extended ops only ever clear z, for multi-word chains
            ccr_next[crf_pkg::CCR_Z] = is_ext ?
              (f_z & ccr_reg[crf_pkg::CCR_Z]) : f_z;
            ccr_next[crf_pkg::CCR_V] = f_v;
            ccr_next[crf_pkg::CCR_C] = f_c;
          end
        end else begin
          cnt_next = cnt_reg - 5'h01;
        end
      end
      ST_SLEEP: begin
        if (irq_accept) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_VECTOR;
    endcase
    // a branch target beats the sequential step
    if (pc_ok) begin
      if (pc_load) begin
        pc_next = pc_target;
      end else if (fetch_take) begin
        pc_next = pc_reg + crf_pkg::PC_STEP;
      end
    end
    case (ccr_op)
      crf_pkg::CC_LOAD: ccr_next = ccr_val;
      crf_pkg::CC_AND: ccr_next = ccr_next & ccr_val;
      crf_pkg::CC_OR: ccr_next = ccr_next | ccr_val;
      crf_pkg::CC_XOR: ccr_next = ccr_next ^ ccr_val;
      default: ccr_next = ccr_next;
    endcase
    // shift, logic and bit ops write only the flags they affect
    ccr_next = (ccr_next & ~flag_wr_mask)
               | (flag_wr_val & flag_wr_mask);
    // mask set wins over any clear in the same cycle
    if (exc_start) begin
      ccr_next[crf_pkg::CCR_I] = 1'b1;
    end
  end

  // only the mask bit has a documented reset value
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state_reg <= ST_VECTOR;
      pc_reg <= 24'h00_0000;
      ccr_reg <= crf_pkg::CCR_RESET;
      cnt_reg <= 5'h00;
      op_reg <= crf_pkg::ALU_ADD;
      size_reg <= crf_pkg::SZ_BYTE;
      a_reg <= 32'h0000_0000;
      b_reg <= 32'h0000_0000;
      cin_reg <= 1'b0;
      res_reg <= 32'h0000_0000;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      ccr_reg <= ccr_next;
      cnt_reg <= cnt_next;
      op_reg <= op_next;
      size_reg <= size_next;
      a_reg <= a_next;
      b_reg <= b_next;
      cin_reg <= cin_next;
      res_reg <= res_next;
      done_reg <= done_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // upper pc bits do not reach the 64-Kbyte fetch bus
  assign fetch_addr = {pc_reg[15:1], 1'b0};
  assign program_counter = pc_reg;
  assign condition_code_register = ccr_reg;
  assign bcc_taken = cond_eval(bcc_cond, ccr_reg);
  // nmi ignores the mask; nothing is taken before the vector loads
  assign irq_accept = (state_reg != ST_VECTOR)
                      && (nmi_req || (irq_req
                      && !ccr_reg[crf_pkg::CCR_I]));
  assign core_ready = (state_reg == ST_RUN);
  assign alu_busy = (state_reg == ST_BUSY);
  assign alu_done = done_reg;
  assign alu_result = res_reg;
  assign power_down = (state_reg == ST_SLEEP);

endmodule // crf_core_regs
`default_nettype wire

//--- crf_core_regs_props.sv
// concurrent checks on the cpu register file top ports
`timescale 1ns/10ps
`default_nettype none
module crf_core_regs_props (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic fetch_take,
  input wire logic pc_load,
  input wire logic [23:0] program_counter,
  input wire logic core_ready,
  input wire logic exc_start,
  input wire logic nmi_req,
  input wire logic irq_accept,
  input wire crf_pkg::crf_ccop_e ccr_op,
  input wire logic [7:0] flag_wr_mask,
  input wire logic [7:0] condition_code_register,
  input wire logic alu_req,
  input wire crf_pkg::crf_aluop_e alu_op,
  input wire logic alu_busy,
  input wire logic alu_done,
  input wire logic sleep_req,
  input wire logic power_down
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic go, go_s, go_l;
  ////////////////////////////////////////
  // accepted requests
  assign go = alu_req && core_ready;
  assign go_s = alu_op == crf_pkg::ALU_MULB || alu_op == crf_pkg::ALU_DIVB;
  assign go_l = alu_op == crf_pkg::ALU_MULW || alu_op == crf_pkg::ALU_DIVW;
  reset_mask_a: assert property (
    $rose(rst_n) |-> condition_code_register == 8'h80)
    else $error("mask clear after reset");
  exc_mask_a: assert property (
    exc_start |=> condition_code_register[7])
    else $error("mask clear after exception");
  irq_gate_a: assert property (
    irq_accept && !nmi_req |-> !condition_code_register[7])
    else $error("interrupt accepted while masked");
  fetch_step_a: assert property (
    core_ready && fetch_take && !pc_load
      |=> program_counter == $past(program_counter) + 24'h00_0002)
    else $error("pc did not step one word");
  add_len_a: assert property (
    go && alu_op < crf_pkg::ALU_MULB
      |=> alu_busy [*2] ##1 (alu_done && !alu_busy))
    else $error("add length wrong");
  short_len_a: assert property (
    go && go_s |-> ##14 !alu_done ##1 alu_done)
    else $error("short muldiv length wrong");
  long_len_a: assert property (
    go && go_l |-> ##22 !alu_done ##1 alu_done)
    else $error("long muldiv length wrong");
  sleep_enter_a: assert property (
    sleep_req && core_ready && !alu_req |=> power_down)
    else $error("sleep did not power down");
  flag_hold_a: assert property (
    !alu_busy && !exc_start && ccr_op == crf_pkg::CC_NONE
      && flag_wr_mask == 8'h00 |=> $stable(condition_code_register))
    else $error("flags changed");
endmodule // crf_core_regs_props
bind crf_core_regs crf_core_regs_props i_crf_core_regs_props (.*);
`default_nettype wire

//--- crf_core_regs_tb.sv
// self-checking bench for the cpu register file
`timescale 1ns/10ps
`default_nettype none
module crf_core_regs_tb;
  localparam logic [23:0] START_PC = 24'h00_0135;
  logic clk_sys, rst_n, wr_en, sp_push, sp_pop, fetch_take, pc_load;
  logic vec_valid, core_ready, exc_start, irq_req, nmi_req, irq_accept;
  logic bcc_taken, alu_req, alu_busy, alu_done, sleep_req, power_down;
  logic [2:0] rd_a_idx, rd_b_idx, wr_idx;
  logic [3:0] bcc_cond;
  logic [7:0] ccr_val, flag_wr_mask, flag_wr_val, condition_code, x;
  logic [15:0] fetch_addr;
  logic [23:0] vec_addr, pc_target, program_counter;
  logic [31:0] rd_a_data, rd_b_data, wr_data, stack_pointer, e;
  logic [31:0] alu_a, alu_b, alu_result, mem [8], ma [4], mb [4], mr [4];
  logic [36:0] r;
  crf_pkg::crf_view_e rd_a_view, rd_b_view, wr_view;
  crf_pkg::crf_ccop_e ccr_op;
  crf_pkg::crf_aluop_e alu_op, mop [4];
  crf_pkg::crf_size_e alu_size;
  int err_count, tests_run, seed, n, w;
  crf_dec_model #(.START(START_PC)) i_crf_dec_model (.*);
  crf_core_regs i_crf_core_regs (.*, .condition_code_register(condition_code));
  ////////////////////////////////////////
  task automatic cyc(input int k);
    repeat (k) @(negedge clk_sys);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic summarize;
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one request, count cycles to done, bounded
  task automatic alu_go;
    alu_req = 1'b1;
    cyc(1);
    alu_req = 1'b0;
    n = 0;
    while (alu_done !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
  endtask
  function automatic logic [31:0] vr(logic [31:0] v, crf_pkg::crf_view_e s);
    case (s)
      crf_pkg::VIEW_EXT: return v >> 16;
      crf_pkg::VIEW_BASE: return v & 32'hffff;
      crf_pkg::VIEW_HIGH: return v >> 8 & 32'hff;
      crf_pkg::VIEW_LOW: return v & 32'hff;
      default: return v;
    endcase
  endfunction
  function automatic logic [31:0] vw(logic [31:0] o, d,
                                     crf_pkg::crf_view_e s);
    case (s)
      crf_pkg::VIEW_EXT: o[31:16] = d[15:0];
      crf_pkg::VIEW_BASE: o[15:0] = d[15:0];
      crf_pkg::VIEW_HIGH: o[15:8] = d[7:0];
      crf_pkg::VIEW_LOW: o[7:0] = d[7:0];
      default: o = d;
    endcase
    return o;
  endfunction
  // {h, n, z, v, c, result}
  function automatic logic [36:0] fl(int sb, int k, logic [31:0] a, b);
    logic [32:0] f;
    logic [31:0] m, q, l;
    logic h;
    m = ~(32'hffff_ffff << k);
    a &= m;
    b &= m;
    f = sb ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
    l = m >> 4;
    h = sb ? (a & l) < (b & l) : (a & l) + (b & l) > l;
    q = f[31:0] & m;
    return {h, q[k-1], q == 0,
            (a[k-1] ^ q[k-1]) & (a[k-1] ^ b[k-1] ^ !sb), f[k], q};
  endfunction
  ////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  // the whole sequence needs under 2000 cycles
  initial begin
    #100000;
    err_count++;
    summarize();
  end
  initial begin
    seed = 32'he08e;
    {rst_n, wr_en, sp_push, sp_pop, fetch_take, pc_load, exc_start} = '0;
    {irq_req, nmi_req, alu_req, sleep_req, rd_a_idx, rd_b_idx} = '0;
    {wr_idx, bcc_cond, ccr_val, flag_wr_mask, flag_wr_val} = '0;
    {wr_data, pc_target, alu_a, alu_b} = '0;
    rd_a_view = crf_pkg::VIEW_LONG;
    rd_b_view = crf_pkg::VIEW_LONG;
    wr_view = crf_pkg::VIEW_LONG;
    ccr_op = crf_pkg::CC_NONE;
    alu_op = crf_pkg::ALU_ADD;
    alu_size = crf_pkg::SZ_BYTE;
    foreach (mem[i]) mem[i] = '0;
    mop = '{crf_pkg::ALU_MULB, crf_pkg::ALU_MULW, crf_pkg::ALU_DIVB,
            crf_pkg::ALU_DIVW};
    ma = '{32'hf3, 32'hff01, 32'h123, 32'h10005};
    mb = '{32'h11, 32'h102, 32'h0, 32'h10};
    mr = '{32'h1023, 32'h100ff02, 32'hffff, 32'h51000};
    cyc(3);
    rst_n = 1'b1;
    cyc(1);
    chk(condition_code, 32'h80);
    chk(program_counter, START_PC);
    // random view writes and reads
    repeat (40) begin
      e = $random(seed);
      wr_idx = e[2:0];
      wr_view = crf_pkg::crf_view_e'(e[5:3] % 3'h5);
      wr_data = $random(seed);
      wr_en = 1'b1;
      mem[wr_idx] = vw(mem[wr_idx], wr_data, wr_view);
      cyc(1);
      wr_en = 1'b0;
      rd_a_idx = wr_idx;
      rd_b_idx = e[10:8];
      rd_b_view = crf_pkg::crf_view_e'(e[14:12] % 3'h5);
      cyc(1);
      chk(rd_a_data, mem[rd_a_idx]);
      chk(rd_b_data, vr(mem[rd_b_idx], rd_b_view));
    end
    // push then pop
    sp_push = 1'b1;
    cyc(1);
    {sp_push, sp_pop} = 2'b01;
    chk(stack_pointer, mem[7] - 32'h2);
    cyc(1);
    sp_pop = 1'b0;
    chk(stack_pointer, mem[7]);
    fetch_take = 1'b1;
    cyc(2);
    fetch_take = 1'b0;
    cyc(1);
    chk(program_counter, START_PC + 24'h4);
    chk(fetch_addr, 16'h0138);
    // load beats a same-cycle fetch step
    {pc_load, fetch_take} = 2'b11;
    pc_target = 24'h12_3457;
    cyc(1);
    {pc_load, fetch_take} = 2'b00;
    cyc(1);
    chk(program_counter, 24'h12_3457);
    chk(fetch_addr, 16'h3456);
    for (int i = 0; i < 10; i++) begin
      e = $random(seed);
      ccr_op = crf_pkg::crf_ccop_e'(i % 5);
      ccr_val = e[7:0];
      flag_wr_mask = (i % 5 == 0) ? e[15:8] : 8'h00;
      flag_wr_val = e[23:16];
      case (ccr_op)
        crf_pkg::CC_LOAD: x = ccr_val;
        crf_pkg::CC_AND: x = condition_code & ccr_val;
        crf_pkg::CC_OR: x = condition_code | ccr_val;
        crf_pkg::CC_XOR: x = condition_code ^ ccr_val;
        default: x = (condition_code & ~flag_wr_mask) | (flag_wr_val & flag_wr_mask);
      endcase
      cyc(1);
      ccr_op = crf_pkg::CC_NONE;
      flag_wr_mask = 8'h00;
      cyc(2);
      chk(condition_code, x);
    end
    ccr_op = crf_pkg::CC_LOAD;
    ccr_val = 8'h00;
    cyc(1);
    ccr_op = crf_pkg::CC_NONE;
    irq_req = 1'b1;
    bcc_cond = 4'h6;
    #1;
    chk(irq_accept, 32'h1);
    chk(bcc_taken, 32'h1);
    exc_start = 1'b1;
    cyc(1);
    exc_start = 1'b0;
    chk(condition_code[7], 32'h1);
    chk(irq_accept, 32'h0);
    nmi_req = 1'b1;
    #1;
    chk(irq_accept, 32'h1);
    cyc(1);
    {nmi_req, irq_req} = 2'b00;
    // add, subtract, compare at each size; late rounds use equal operands
    for (int i = 0; i < 12; i++) begin
      alu_a = $random(seed);
      alu_b = (i > 8) ? alu_a : $random(seed);
      alu_op = crf_pkg::crf_aluop_e'(2 * (i % 3));
      alu_size = crf_pkg::crf_size_e'((i / 3) % 3);
      w = 8 << ((i / 3) % 3);
      r = fl(int'(i % 3 != 0), w, alu_a, alu_b);
      alu_go();
      chk(n, 2);
      if (i % 3 != 2)
        chk(alu_result & ~(32'hffff_ffff << w), r[31:0]);
      chk({condition_code[5], condition_code[3:0]}, r[36:32]);
    end
    for (int i = 0; i < 4; i++) begin
      alu_op = mop[i];
      alu_a = ma[i];
      alu_b = mb[i];
      x = condition_code;
      alu_go();
      chk(n, (i % 2) ? 22 : 14);
      chk(alu_result, mr[i]);
      chk(condition_code, x);
    end
    // fetch refused while powered down
    sleep_req = 1'b1;
    cyc(1);
    sleep_req = 1'b0;
    fetch_take = 1'b1;
    chk(power_down, 32'h1);
    cyc(1);
    {fetch_take, nmi_req} = 2'b01;
    chk(program_counter, 24'h12_3457);
    cyc(1);
    nmi_req = 1'b0;
    cyc(1);
    chk(power_down, 32'h0);
    summarize();
  end
endmodule // crf_core_regs_tb
`default_nettype wire

//--- crf_dec_model.sv
// decoder-side model: issues the reset start vector once
`timescale 1ns/10ps
`default_nettype none
module crf_dec_model #(
  parameter logic [23:0] START = 24'h00_0135
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic vec_valid,
  output logic [23:0] vec_addr
);
  logic sent_reg;
  // one pulse at the first edge after release
  assign vec_valid = rst_n && !sent_reg;
  // address inverted off the pulse so a stale value cannot pass
  assign vec_addr = vec_valid ? START : ~START;
  always_ff @(posedge clk_sys) begin
    sent_reg <= rst_n;
  end
endmodule // crf_dec_model
`default_nettype wire

//--- crf_flag_unit.sv
// add/subtract datapath with condition flags at byte, word and long size
`timescale 1ns/10ps
`default_nettype none
module crf_flag_unit (
  input wire logic [31:0] op_a,
  input wire logic [31:0] op_b,
  input wire logic carry_in,
  input wire crf_pkg::crf_aluop_e op,
  input wire crf_pkg::crf_size_e size,
  output logic [31:0] sum_result,
  output logic flag_n,
  output logic flag_z,
  output logic flag_v,
  output logic flag_c,
  output logic flag_h
);

  logic [4:0] k;
  logic sub, cin;
  logic [31:0] x, y, xs, ys;
  logic [32:0] sum;
  logic cy, hc;

  // left-justified operands let one adder and one h bit serve all sizes
  always_comb begin
    case (size)
      crf_pkg::SZ_BYTE: k = 5'h18;
      crf_pkg::SZ_WORD: k = 5'h10;
      default: k = 5'h00;
    endcase
    sub = (op != crf_pkg::ALU_ADD) && (op != crf_pkg::ALU_ADDX);
    x = (op == crf_pkg::ALU_NEG) ? 32'h0000_0000 : op_a;
    y = (op == crf_pkg::ALU_NEG) ? op_a : op_b;
    case (op)
      crf_pkg::ALU_ADD: cin = 1'b0;
      crf_pkg::ALU_ADDX: cin = carry_in;
      crf_pkg::ALU_SUBX: cin = ~carry_in;
      default: cin = 1'b1;
    endcase
    xs = x << k;
    ys = (sub ? ~y : y) << k;
    sum = {1'b0, xs} + {1'b0, ys} + (33'(cin) << k);
    cy = sum[32];
    hc = xs[crf_pkg::JUST_HALF] ^ ys[crf_pkg::JUST_HALF]
         ^ sum[crf_pkg::JUST_HALF];
    sum_result = sum[31:0] >> k;
    flag_n = sum[crf_pkg::JUST_MSB];
    flag_z = (sum[31:0] == 32'h0000_0000);
    flag_v = (xs[crf_pkg::JUST_MSB] == ys[crf_pkg::JUST_MSB])
             && (sum[crf_pkg::JUST_MSB] != xs[crf_pkg::JUST_MSB]);
    flag_c = sub ? ~cy : cy; // borrow on subtract
    flag_h = sub ? ~hc : hc; // bit 3, 11 or 27
  end

endmodule // crf_flag_unit
`default_nettype wire

//--- crf_gpr_bank.sv
// eight general registers with view access and stack pointer stepping
`timescale 1ns/10ps
`default_nettype none
module crf_gpr_bank (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [2:0] rd_a_idx,
  input wire crf_pkg::crf_view_e rd_a_view,
  output logic [31:0] rd_a_data,
  input wire logic [2:0] rd_b_idx,
  input wire crf_pkg::crf_view_e rd_b_view,
  output logic [31:0] rd_b_data,
  input wire logic wr_en,
  input wire logic [2:0] wr_idx,
  input wire crf_pkg::crf_view_e wr_view,
  input wire logic [31:0] wr_data,
  input wire logic sp_push,
  input wire logic sp_pop,
  output logic [31:0] stack_pointer
);

  logic [31:0] mem_reg [crf_pkg::GPR_COUNT];
  logic [31:0] mem_next [crf_pkg::GPR_COUNT];
  logic [31:0] rd_a_reg, rd_a_next, rd_b_reg, rd_b_next;

  // stack step first, so an explicit write to the same register wins
  always_comb begin
    mem_next = mem_reg;
    if (sp_push && !sp_pop) begin
      mem_next[crf_pkg::SP_IDX] = mem_reg[crf_pkg::SP_IDX]
                                  - crf_pkg::SP_STEP;
    end else if (sp_pop && !sp_push) begin
      mem_next[crf_pkg::SP_IDX] = mem_reg[crf_pkg::SP_IDX]
                                  + crf_pkg::SP_STEP;
    end
    if (wr_en) begin
      mem_next[wr_idx] = crf_pkg::view_write(mem_reg[wr_idx], wr_data,
                                             wr_view);
    end
    // each port picks its own view
    rd_a_next = crf_pkg::view_read(mem_reg[rd_a_idx], rd_a_view);
    rd_b_next = crf_pkg::view_read(mem_reg[rd_b_idx], rd_b_view);
  end

  // reads show the value before a same-cycle write
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < crf_pkg::GPR_COUNT; i++) begin
        mem_reg[i] <= crf_pkg::GPR_RESET;
      end
      rd_a_reg <= crf_pkg::GPR_RESET;
      rd_b_reg <= crf_pkg::GPR_RESET;
    end else begin
      mem_reg <= mem_next;
      rd_a_reg <= rd_a_next;
      rd_b_reg <= rd_b_next;
    end
  end

  assign rd_a_data = rd_a_reg;
  assign rd_b_data = rd_b_reg;
  assign stack_pointer = mem_reg[crf_pkg::SP_IDX];

endmodule // crf_gpr_bank
`default_nettype wire

//--- crf_pkg.sv
// constants, types and view helpers for the cpu register file
//
// Overview of operation
// - core runs in one normal mode with a 64-Kbyte address space.
// - eight identical 32-bit general registers, usable as address or data.
// - data operands read and written at 32, 16 or 8 bit width.
// - each register splits into independent extended and base 16-bit halves.
// - each base half splits into a high byte and a low byte.
// - width view chosen per register and per access, independently.
// - eighth register doubles as stack pointer for exceptions and calls.
// - program counter is 24 bits and holds the next instruction address.
// - fetches treat the lowest program counter bit as zero.
// - reset handling loads the program counter from the reset vector.
// - reset sets the interrupt mask bit; other flag bits are left undefined.
// - mask bit set blocks all interrupts except the non-maskable one.
// - every exception sequence sets the interrupt mask bit at its start.
// - bit 6 is a user bit, reached by load/store/and/or/xor ops.
// - n, z, v, c feed branch tests; non-flag ops leave flags alone.
// - byte add/sub/cmp/neg set half-carry from bit 3 carry or borrow.
// - word add/sub/cmp/neg set half-carry from bit 11 carry or borrow.
// - long add/sub/cmp/neg set half-carry from bit 27 carry or borrow.
// - register add and subtract finish in 2 states.
// - short multiply/divide take 14 states, long ones 22 states.
// - sleep instruction moves the core into power-down.
// - overflow flag shows arithmetic overflow; zero flag shows zero result.
// - carry flag shows carry, borrow or shifted-out bit; bit accumulator.
// - negative flag takes the result's most significant bit.
package crf_pkg;

  localparam int GPR_COUNT = 8;
  localparam int GPR_W = 32;
  localparam int IDX_W = 3;
  localparam int PC_W = 24;
  localparam int ADDR_W = 16;
  localparam int CCR_W = 8;
  localparam int CNT_W = 5;

  // condition code field positions
  localparam int CCR_I = 7;
  localparam int CCR_UI = 6;
  localparam int CCR_H = 5;
  localparam int CCR_U = 4;
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;
  localparam logic [7:0] CCR_RESET = 8'h80;

  localparam logic [2:0] SP_IDX = 3'h7;
  localparam logic [31:0] SP_STEP = 32'h0000_0002;
  localparam logic [23:0] PC_STEP = 24'h00_0002;
  localparam logic [31:0] GPR_RESET = 32'h0000_0000;

  // execution lengths in states (one state per clk_sys cycle)
  localparam int LAT_ADDSUB = 2;
  localparam int LAT_MULDIV_SHORT = 14;
  localparam int LAT_MULDIV_LONG = 22;

  // left-justified operand: carry into this bit is the half carry
  localparam int JUST_HALF = 28;
  localparam int JUST_MSB = 31;

  typedef enum logic [2:0] {
    VIEW_LONG, VIEW_EXT, VIEW_BASE, VIEW_HIGH, VIEW_LOW
  } crf_view_e;
  typedef enum logic [2:0] {
    CC_NONE, CC_LOAD, CC_AND, CC_OR, CC_XOR
  } crf_ccop_e;
  typedef enum logic [3:0] {
    ALU_ADD, ALU_ADDX, ALU_SUB, ALU_SUBX, ALU_CMP, ALU_NEG,
    ALU_MULB, ALU_DIVB, ALU_MULW, ALU_DIVW
  } crf_aluop_e;
  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} crf_size_e;

  // right-justified, zero-extended value of one view
  function automatic logic [31:0] view_read(input logic [31:0] w,
                                            input crf_view_e v);
    case (v)
      VIEW_EXT: view_read = {16'h0000, w[31:16]};
      VIEW_BASE: view_read = {16'h0000, w[15:0]};
      VIEW_HIGH: view_read = {24'h00_0000, w[15:8]};
      VIEW_LOW: view_read = {24'h00_0000, w[7:0]};
      default: view_read = w;
    endcase
  endfunction

  // merge right-justified data into the addressed bits only
  function automatic logic [31:0] view_write(input logic [31:0] old,
                                             input logic [31:0] d,
                                             input crf_view_e v);
    logic [31:0] r;
    r = old;
    case (v)
      VIEW_EXT: r[31:16] = d[15:0];
      VIEW_BASE: r[15:0] = d[15:0];
      VIEW_HIGH: r[15:8] = d[7:0];
      VIEW_LOW: r[7:0] = d[7:0];
      default: r = d;
    endcase
    return r;
  endfunction

endpackage
